// ### design/osc_ctrl_params.svh
`ifndef OSC_CTRL_PARAMS_SVH
`define OSC_CTRL_PARAMS_SVH

// Register byte addresses
`define OSC_CONTROL_ADDR    12'h000
`define CLOCK_DIVISOR_ADDR  12'h004
`define PLL_FEEDBACK_ADDR   12'h008
`define RC_TUNING_ADDR      12'h00C

// Oscillator control fields
`define NEW_SRC_LSB         8
`define CLOCK_LOCK_BIT      7
`define CLOCK_FAIL_BIT      3
`define SEC_OSC_EN_BIT      1
`define SWITCH_REQ_BIT      0

// Clock divisor fields
`define RECOVER_BIT         15
`define REDUCTION_LSB       12
`define REDUCTION_EN_BIT    11
`define FAST_RC_POST_LSB    8
`define PLL_POST_LSB        6
`define PLL_PRE_LSB         0

// Reset values
`define REDUCTION_RESET     3'h3
`define PLL_POST_RESET      2'h1
`define PLL_MULT_RESET      9'h030
`define OSC_ENABLE_RESET    5'h10

// New clock cycles counted before the switch-over
`define NEW_CLOCK_SETTLE    4'hA

`endif

// ### design/osc_ctrl_pkg.sv
package osc_ctrl_pkg;

  typedef enum logic [2:0] {
    SRC_FAST_RC       = 3'b000,
    SRC_FAST_RC_PLL   = 3'b001,
    SRC_PRIMARY       = 3'b010,
    SRC_PRIMARY_PLL   = 3'b011,
    SRC_SECONDARY     = 3'b100,
    SRC_LOW_POWER_RC  = 3'b101,
    SRC_FAST_RC_DIV16 = 3'b110,
    SRC_FAST_RC_POST  = 3'b111
  } clk_source_t;

  typedef enum logic [2:0] {
    SW_IDLE       = 3'b000,
    SW_COMPARE    = 3'b001,
    SW_WAIT_READY = 3'b010,
    SW_SETTLE     = 3'b011
  } switch_state_t;

  typedef struct packed {
    logic fastRc;
    logic primary;
    logic secondary;
    logic lowPowerRc;
    logic pll;
  } osc_enable_t;

  typedef struct packed {
    logic [5:0] prescale;
    logic [9:0] multiplier;
    logic [3:0] postscale;
  } pll_setting_t;

  typedef struct packed {
    logic       startupDone;
    logic       pllLock;
    logic       oscFail;
    logic       newClockToggle;
    logic       switchConfigBit;
    logic [2:0] powerOnSource;
    logic [1:0] primarySubmode;
    logic       watchdogEnable;
  } pin_sample_t;

endpackage

// ### design/osc_switch_control.sv
`timescale 1ns/10ps
// How it works
// - Enable bit runs the secondary oscillator
// - Request bit starts switch, cleared when done
// - Registers reset only by power-on reset
// - Interrupt clears reduction enable when recovery set
// - Reduction code divides CPU clock by 2^code
// - Reduction enable off forces ratio 1:1
// - Fast RC postscaler divides 1..64, 256
// - PLL postscaler divides 2, 4, 8
// - PLL prescaler divides field plus two
// - PLL multiplier is field plus two
// - Six-bit two's-complement fast RC trim
// - Config bit zero enables switching and monitor
// - Switching disabled: source fixed, request held zero
// - Equal sources abort switch, clear request
// - Valid switch clears lock and fail flags
// - Start new source, wait timer and lock
// - Count ten new clocks, then switch over
// - Old source off unless still needed
// - Monitor keeps low-power RC always running
// - Failure traps, falls back to fast RC, or to fast RC with PLL if old source used PLL
// - Three-bit source encoding for both fields
// - Fail flag set by monitor, software clears
`include "osc_ctrl_params.svh"

module osc_switch_control
  import osc_ctrl_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          startupTimerDone,
  input  wire logic          pllLockDetect,
  input  wire logic          oscFail,
  input  wire logic          newClockToggle,
  input  wire logic          switchConfigBit,
  input  wire logic [2:0]    powerOnSourceConfig,
  input  wire logic [1:0]    primarySubmodeConfig,
  input  wire logic          watchdogEnable,
  input  wire logic          interruptRequest,
  output osc_enable_t        oscEnable,
  output clk_source_t        currentSource,
  output pll_setting_t       pllSetting,
  output logic      [8:0]    fastRcDivide,
  output logic      [5:0]    rcTrim,
  output logic               clockFailTrap,
  output logic               cpuClockEnable
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  pin_sample_t   pinIn;
  pin_sample_t   syncA;
  pin_sample_t   syncB;
  pin_sample_t   syncC;
  logic [1:0]    initCount;
  logic          configValid;
  logic          switchConfigLatched;
  logic [1:0]    submodeLatched;
  logic          watchdogLatched;
  logic          loadConfig;
  logic          switchEnabled;
  switch_state_t state;
  clk_source_t   newSourceSelect;
  logic          switchRequest;
  logic          clockFailFlag;
  logic          pllLocked;
  logic          secondaryOscEnable;
  logic          clockLockBit;
  logic [3:0]    settleCount;
  logic          recoverOnInterrupt;
  logic [2:0]    reductionSelect;
  logic          reductionEnable;
  logic [2:0]    fastRcPostscaler;
  logic [1:0]    pllPostscaler;
  logic [4:0]    pllPrescaler;
  logic [8:0]    pllMultiplier;
  logic [6:0]    cpuDivCount;
  logic [6:0]    lastCount;
  logic [7:0]    cpuRatio;
  logic          oscWrite;
  logic          divWrite;
  logic          fbdWrite;
  logic          tunWrite;
  logic          mapped;
  logic [31:0]   readData;
  logic          newClockEdge;
  logic          failEdge;
  logic          newReady;
  osc_enable_t   newNeed;
  osc_enable_t   next_oscEnable;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic osc_enable_t sourceNeeds(input clk_source_t src);
    osc_enable_t need;
    need = '0;
    case (src)
      SRC_FAST_RC, SRC_FAST_RC_DIV16, SRC_FAST_RC_POST:
        need.fastRc = 1'b1;
      SRC_FAST_RC_PLL:
      begin
        need.fastRc = 1'b1;
        need.pll    = 1'b1;
      end
      SRC_PRIMARY:
        need.primary = 1'b1;
      SRC_PRIMARY_PLL:
      begin
        need.primary = 1'b1;
        need.pll     = 1'b1;
      end
      SRC_SECONDARY:
        need.secondary = 1'b1;
      SRC_LOW_POWER_RC:
        need.lowPowerRc = 1'b1;
      default:
        need = '0;
    endcase
    return need;
  endfunction

  function automatic logic usesPll(input clk_source_t src);
    return (src == SRC_FAST_RC_PLL) || (src == SRC_PRIMARY_PLL);
  endfunction

  function automatic logic [8:0] fastRcDivideOf(input logic [2:0] code);
    if (code == 3'h7)
      return 9'h100;
    else
      return 9'(9'h001 << code);
  endfunction

  function automatic logic [3:0] pllPostOf(input logic [1:0] code);
    case (code)
      2'h0:    return 4'h2;
      2'h1:    return 4'h4;
      2'h3:    return 4'h8;
      default: return 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  assign pinIn = '{startupDone:     startupTimerDone,
                   pllLock:         pllLockDetect,
                   oscFail:         oscFail,
                   newClockToggle:  newClockToggle,
                   switchConfigBit: switchConfigBit,
                   powerOnSource:   powerOnSourceConfig,
                   primarySubmode:  primarySubmodeConfig,
                   watchdogEnable:  watchdogEnable};

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end
    else
    begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  assign newClockEdge = syncB.newClockToggle ^ syncC.newClockToggle;
  assign failEdge     = syncB.oscFail & ~syncC.oscFail;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture after power-on reset

  assign loadConfig = (initCount == 2'h2) && !configValid;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      initCount           <= 2'h0;
      configValid         <= 1'b0;
      switchConfigLatched <= 1'b1;
      submodeLatched      <= 2'h0;
      watchdogLatched     <= 1'b0;
    end
    else
    begin
      if (initCount != 2'h2)
        initCount <= initCount + 2'h1;
      if (loadConfig)
      begin
        configValid         <= 1'b1;
        switchConfigLatched <= syncB.switchConfigBit;
        submodeLatched      <= syncB.primarySubmode;
        watchdogLatched     <= syncB.watchdogEnable;
      end
    end
  end

  assign switchEnabled = configValid && !switchConfigLatched;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  assign oscWrite = psel && penable && pwrite && (paddr == `OSC_CONTROL_ADDR);
  assign divWrite = psel && penable && pwrite && (paddr == `CLOCK_DIVISOR_ADDR);
  assign fbdWrite = psel && penable && pwrite && (paddr == `PLL_FEEDBACK_ADDR);
  assign tunWrite = psel && penable && pwrite && (paddr == `RC_TUNING_ADDR);
  assign mapped   = (paddr == `OSC_CONTROL_ADDR) || (paddr == `CLOCK_DIVISOR_ADDR) ||
                    (paddr == `PLL_FEEDBACK_ADDR) || (paddr == `RC_TUNING_ADDR);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  always_comb
  begin
    case (paddr)
      `OSC_CONTROL_ADDR:
        readData = {16'h0000, 1'b0, currentSource, 1'b0, newSourceSelect, clockLockBit, 1'b0,
                    pllLocked, 1'b0, clockFailFlag, 1'b0, secondaryOscEnable, switchRequest};
      `CLOCK_DIVISOR_ADDR:
        readData = {16'h0000, recoverOnInterrupt, reductionSelect, reductionEnable,
                    fastRcPostscaler, pllPostscaler, 1'b0, pllPrescaler};
      `PLL_FEEDBACK_ADDR:
        readData = {23'h000000, pllMultiplier};
      `RC_TUNING_ADDR:
        readData = {26'h0000000, rcTrim};
      default:
        readData = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= readData;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock switch sequence and oscillator control register

  assign newNeed  = sourceNeeds(newSourceSelect);
  assign newReady = (!newNeed.primary || submodeLatched == 2'h0 || syncB.startupDone) &&
                    (!newNeed.pll || syncB.pllLock);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state              <= SW_IDLE;
      currentSource      <= SRC_FAST_RC;
      newSourceSelect    <= SRC_FAST_RC;
      switchRequest      <= 1'b0;
      clockFailFlag      <= 1'b0;
      pllLocked          <= 1'b0;
      secondaryOscEnable <= 1'b0;
      clockLockBit       <= 1'b0;
      settleCount        <= 4'h0;
      clockFailTrap      <= 1'b0;
    end
    else
    begin
      clockFailTrap <= 1'b0;
      pllLocked     <= syncB.pllLock;
      if (oscWrite)
      begin
        secondaryOscEnable <= pwdata[`SEC_OSC_EN_BIT];
        clockLockBit       <= pwdata[`CLOCK_LOCK_BIT];
        if (!switchRequest)
          newSourceSelect <= clk_source_t'(pwdata[`NEW_SRC_LSB +: 3]);
        if (switchEnabled && pwdata[`SWITCH_REQ_BIT])
          switchRequest <= 1'b1;
        if (!pwdata[`CLOCK_FAIL_BIT])
          clockFailFlag <= 1'b0;
      end
      if (loadConfig)
      begin
        currentSource   <= clk_source_t'(syncB.powerOnSource);
        newSourceSelect <= clk_source_t'(syncB.powerOnSource);
      end
      case (state)
        SW_IDLE:
        begin
          if (switchRequest && switchEnabled)
            state <= SW_COMPARE;
        end
        SW_COMPARE:
        begin
          if (newSourceSelect == currentSource)
          begin
            switchRequest <= 1'b0;
            state         <= SW_IDLE;
          end
          else
          begin
            pllLocked     <= 1'b0;
            clockFailFlag <= 1'b0;
            state         <= SW_WAIT_READY;
          end
        end
        SW_WAIT_READY:
        begin
          settleCount <= 4'h0;
          if (newReady)
            state <= SW_SETTLE;
        end
        SW_SETTLE:
        begin
          if (newClockEdge)
          begin
            if (settleCount == `NEW_CLOCK_SETTLE - 4'h1)
            begin
              currentSource <= newSourceSelect;
              switchRequest <= 1'b0;
              state         <= SW_IDLE;
            end
            else
              settleCount <= settleCount + 4'h1;
          end
        end
        default:
          state <= SW_IDLE;
      endcase
      if (switchEnabled && failEdge)
      begin
        clockFailFlag <= 1'b1;
        clockFailTrap <= 1'b1;
        currentSource <= usesPll(currentSource) ? SRC_FAST_RC_PLL : SRC_FAST_RC;
        switchRequest <= 1'b0;
        state         <= SW_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator enables

  always_comb
  begin
    next_oscEnable = sourceNeeds(currentSource);
    if (state == SW_WAIT_READY || state == SW_SETTLE)
      next_oscEnable = osc_enable_t'(next_oscEnable | newNeed);
    if (watchdogLatched || switchEnabled)
      next_oscEnable.lowPowerRc = 1'b1;
    if (secondaryOscEnable)
      next_oscEnable.secondary = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      oscEnable <= osc_enable_t'(`OSC_ENABLE_RESET);
    else
      oscEnable <= next_oscEnable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divisor, feedback and tuning registers

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      recoverOnInterrupt <= 1'b0;
      reductionSelect    <= `REDUCTION_RESET;
      reductionEnable    <= 1'b0;
      fastRcPostscaler   <= 3'h0;
      pllPostscaler      <= `PLL_POST_RESET;
      pllPrescaler       <= 5'h00;
      pllMultiplier      <= `PLL_MULT_RESET;
      rcTrim             <= 6'h00;
    end
    else
    begin
      if (divWrite)
      begin
        recoverOnInterrupt <= pwdata[`RECOVER_BIT];
        reductionSelect    <= pwdata[`REDUCTION_LSB +: 3];
        reductionEnable    <= pwdata[`REDUCTION_EN_BIT];
        fastRcPostscaler   <= pwdata[`FAST_RC_POST_LSB +: 3];
        pllPostscaler      <= pwdata[`PLL_POST_LSB +: 2];
        pllPrescaler       <= pwdata[`PLL_PRE_LSB +: 5];
      end
      if (fbdWrite)
        pllMultiplier <= pwdata[8:0];
      if (tunWrite)
        rcTrim <= pwdata[5:0];
      if (recoverOnInterrupt && interruptRequest)
        reductionEnable <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded divider settings

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pllSetting   <= '0;
      fastRcDivide <= 9'h000;
    end
    else
    begin
      pllSetting.prescale   <= 6'({1'b0, pllPrescaler} + 6'h02);
      pllSetting.multiplier <= 10'({1'b0, pllMultiplier} + 10'h002);
      pllSetting.postscale  <= pllPostOf(pllPostscaler);
      fastRcDivide          <= fastRcDivideOf(fastRcPostscaler);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU clock reduction

  assign cpuRatio  = reductionEnable ? 8'(8'h01 << reductionSelect) : 8'h01;
  assign lastCount = 7'(cpuRatio - 8'h01);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cpuDivCount    <= 7'h00;
      cpuClockEnable <= 1'b0;
    end
    else if (cpuDivCount >= lastCount)
    begin
      cpuDivCount    <= 7'h00;
      cpuClockEnable <= 1'b1;
    end
    else
    begin
      cpuDivCount    <= cpuDivCount + 7'h01;
      cpuClockEnable <= 1'b0;
    end
  end

endmodule // osc_switch_control

// ### sim/osc_source_model.sv
`timescale 1ns/10ps
module osc_source_model
  import osc_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire osc_enable_t oscEnable,
  input  wire logic        failNow,
  output logic             startupTimerDone,
  output logic             pllLockDetect,
  output logic             newClockToggle,
  output logic             oscFail
);
  logic [3:0] oscAge = 4'h0;
  logic [3:0] pllAge = 4'h0;

  initial newClockToggle = 1'b0;
  always #35 newClockToggle = ~newClockToggle;

  always_ff @(posedge clk)
  begin
    if (oscEnable.primary !== 1'b1)
      oscAge <= 4'h0;
    else if (oscAge != 4'hF)
      oscAge <= oscAge + 4'h1;
  end
  always_ff @(posedge clk)
  begin
    if (oscEnable.pll !== 1'b1)
      pllAge <= 4'h0;
    else if (pllAge != 4'hF)
      pllAge <= pllAge + 4'h1;
  end
  assign startupTimerDone = oscAge > 4'h8;
  assign pllLockDetect    = pllAge > 4'h5;
  assign oscFail          = failNow;
endmodule // osc_source_model

// ### sim/osc_switch_control_properties.sv
`timescale 1ns/10ps
module osc_switch_control_properties
  import osc_ctrl_pkg::*;
(
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic         switchConfigBit,
  input wire osc_enable_t  oscEnable,
  input wire clk_source_t  currentSource,
  input wire pll_setting_t pllSetting,
  input wire logic [8:0]   fastRcDivide,
  input wire logic         clockFailTrap,
  input wire logic         cpuClockEnable
);
  logic [2:0] settled;
  logic       ready;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

////////////////////////////////////////////////////////////////////////////////
  // Cycles since reset release
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      settled <= 3'h0;
    else if (settled != 3'h7)
      settled <= settled + 3'h1;
  end
  assign ready = settled == 3'h7;

  sequence trapSeen;
    clockFailTrap;
  endsequence
  sequence fallBack;
    !clockFailTrap && (currentSource inside {SRC_FAST_RC, SRC_FAST_RC_PLL});
  endsequence

////////////////////////////////////////////////////////////////////////////////
  AST_FAST_RC_DIV: assert property (ready |-> fastRcDivide inside
    {9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100}) else $error("fast rc divide off");
  AST_PLL_POST: assert property (ready |-> pllSetting.postscale inside {4'h0, 4'h2, 4'h4, 4'h8})
    else $error("pll postscale off");
  AST_PLL_PRE: assert property (ready |-> pllSetting.prescale inside {[6'h02:6'h21]})
    else $error("pll prescale off");
  AST_PLL_MULT: assert property (ready |-> pllSetting.multiplier inside {[10'h002:10'h201]})
    else $error("pll multiplier off");
  AST_NO_MONITOR: assert property (switchConfigBit |-> !clockFailTrap)
    else $error("trap while monitor off");
  AST_SOURCE_FIXED: assert property (ready && switchConfigBit |=> $stable(currentSource))
    else $error("source moved while switching off");
  AST_LOW_POWER_RC_OSCILLATOR_KEPT: assert property (ready && !switchConfigBit |-> oscEnable.lowPowerRc)
    else $error("low power rc stopped");
  AST_TRAP_FALLBACK: assert property (trapSeen |=> fallBack)
    else $error("no fast rc fallback after trap");
  AST_CPU_PULSE: assert property ($fell(cpuClockEnable) |-> ##[1:130] cpuClockEnable)
    else $error("cpu enable pulse missing");
endmodule // osc_switch_control_properties

bind osc_switch_control osc_switch_control_properties osc_switch_control_properties_i (
  .clk(clk), .reset_n(reset_n), .switchConfigBit(switchConfigBit), .oscEnable(oscEnable),
  .currentSource(currentSource), .pllSetting(pllSetting), .fastRcDivide(fastRcDivide),
  .clockFailTrap(clockFailTrap), .cpuClockEnable(cpuClockEnable));

// ### sim/tb_top.sv
`timescale 1ns/10ps
`include "osc_ctrl_params.svh"
module tb_top
  import osc_ctrl_pkg::*;
;
  logic         clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  logic         switchConfigBit = 1'b1;
  logic         interruptRequest = 1'b0;
  logic         failNow = 1'b0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         startupTimerDone;
  logic         pllLockDetect;
  logic         newClockToggle;
  logic         oscFail;
  osc_enable_t  oscEnable;
  clk_source_t  currentSource;
  pll_setting_t pllSetting;
  logic [8:0]   fastRcDivide;
  logic [5:0]   rcTrim;
  logic         clockFailTrap;
  logic         cpuClockEnable;
  logic [31:0]  rd;
  logic         err;
  int           badCount = 0;
  int           comparisons = 0;
  int           n;
  int           traps;

  always #25 clk = ~clk;

  osc_switch_control osc_switch_control_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .startupTimerDone(startupTimerDone), .pllLockDetect(pllLockDetect), .oscFail(oscFail),
    .newClockToggle(newClockToggle), .switchConfigBit(switchConfigBit), .powerOnSourceConfig(3'h7),
    .primarySubmodeConfig(2'h1), .watchdogEnable(1'b0), .interruptRequest(interruptRequest),
    .oscEnable(oscEnable), .currentSource(currentSource), .pllSetting(pllSetting),
    .fastRcDivide(fastRcDivide), .rcTrim(rcTrim), .clockFailTrap(clockFailTrap), .cpuClockEnable(cpuClockEnable));

  osc_source_model osc_source_model_i (.clk(clk), .oscEnable(oscEnable), .failNow(failNow),
    .startupTimerDone(startupTimerDone), .pllLockDetect(pllLockDetect), .newClockToggle(newClockToggle),
    .oscFail(oscFail));

////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] expVal, input logic [31:0] gotVal);
    comparisons++;
    if (gotVal !== expVal)
    begin
      badCount++;
      $display("unexpected %s: expected %0h, seen %0h", what, expVal, gotVal);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rcheck(input string what, input logic [11:0] addr, input logic [31:0] expVal);
    apb(1'b0, addr, 32'h0);
    check(what, expVal, rd);
  endtask

  task automatic period(input int expVal);
    repeat (2)
    begin
      n = 0;
      while (cpuClockEnable !== 1'b1 && n < 300)
      begin
        @(negedge clk);
        n++;
      end
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end while (cpuClockEnable !== 1'b1 && n < 300);
    end
    check("cpu ratio", 32'(expVal), 32'(n));
  endtask

  task automatic pulse(input logic fail);
    @(posedge clk);
    if (fail)
      failNow <= 1'b1;
    else
      interruptRequest <= 1'b1;
    traps = 0;
    @(posedge clk);
    interruptRequest <= 1'b0;
    repeat (12)
    begin
      @(negedge clk);
      traps += (clockFailTrap === 1'b1);
    end
    @(posedge clk);
    failNow <= 1'b0;
  endtask

  task automatic wait_switch;
    repeat (80)
    begin
      apb(1'b0, `OSC_CONTROL_ADDR, 32'h0);
      if (rd[0] === 1'b0)
        break;
    end
  endtask

  task automatic report_and_stop;
    if (badCount == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values;
    rcheck("osc", `OSC_CONTROL_ADDR, 32'h7700);
    rcheck("div", `CLOCK_DIVISOR_ADDR, 32'h3040);
    rcheck("fbd", `PLL_FEEDBACK_ADDR, 32'h0030);
    rcheck("tun", `RC_TUNING_ADDR, 32'h0);
    @(negedge clk);
    check("fast rc div", 32'h1, 32'(fastRcDivide));
    check("pll", 32'({6'h02, 10'h032, 4'h4}), 32'(pllSetting));
    apb(1'b0, 12'h010, 32'h0);
    check("slverr", 32'h1, 32'(err));
    check("unmapped", 32'h0, rd);
  endtask

  task automatic test_decode;
    int divTab [8] = '{1, 2, 4, 8, 16, 32, 64, 256};
    int postTab [4] = '{2, 4, 0, 8};
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, `CLOCK_DIVISOR_ADDR, 32'((i << 8) | ((i & 3) << 6) | (i * 4 + 3)));
      repeat (2) @(negedge clk);
      check("fast rc div", 32'(divTab[i]), 32'(fastRcDivide));
      check("postscale", 32'(postTab[i & 3]), 32'(pllSetting.postscale));
      check("prescale", 32'(i * 4 + 5), 32'(pllSetting.prescale));
    end
    apb(1'b1, `PLL_FEEDBACK_ADDR, 32'h01FF);
    repeat (2) @(negedge clk);
    check("multiplier", 32'd513, 32'(pllSetting.multiplier));
    apb(1'b1, `PLL_FEEDBACK_ADDR, 32'h0);
    repeat (2) @(negedge clk);
    check("multiplier", 32'h2, 32'(pllSetting.multiplier));
    apb(1'b1, `RC_TUNING_ADDR, 32'hFFFFFFFF);
    rcheck("tun", `RC_TUNING_ADDR, 32'h003F);
    apb(1'b1, `RC_TUNING_ADDR, 32'h0020);
    @(negedge clk);
    check("trim", 32'h20, 32'(rcTrim));
  endtask

  task automatic test_doze;
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, `CLOCK_DIVISOR_ADDR, 32'(c << 12) | 32'h0840);
      period(1 << c);
    end
    apb(1'b1, `CLOCK_DIVISOR_ADDR, 32'h7040);
    period(1);
    apb(1'b1, `CLOCK_DIVISOR_ADDR, 32'h7840);
    pulse(1'b0);
    rcheck("div", `CLOCK_DIVISOR_ADDR, 32'h7840);
    apb(1'b1, `CLOCK_DIVISOR_ADDR, 32'hF840);
    pulse(1'b0);
    rcheck("div", `CLOCK_DIVISOR_ADDR, 32'hF040);
    period(1);
  endtask

  task automatic test_disabled;
    apb(1'b1, `OSC_CONTROL_ADDR, 32'h0201);
    apb(1'b0, `OSC_CONTROL_ADDR, 32'h0);
    check("osc", 32'h7000, rd & 32'h7001);
    pulse(1'b1);
    check("traps", 32'h0, 32'(traps));
    rcheck("osc", `OSC_CONTROL_ADDR, 32'h7200);
  endtask

  task automatic test_switch;
    rcheck("tun", `RC_TUNING_ADDR, 32'h0);
    apb(1'b1, `OSC_CONTROL_ADDR, 32'h0302);
    apb(1'b1, `OSC_CONTROL_ADDR, 32'h0303);
    apb(1'b0, `OSC_CONTROL_ADDR, 32'h0);
    check("pending", 32'h1, 32'(rd[0]));
    wait_switch;
    check("osc", 32'h3002, rd & 32'h7003);
    @(negedge clk);
    check("source", 32'(SRC_PRIMARY_PLL), 32'(currentSource));
    check("enables", 32'h0F, 32'(oscEnable));
    pulse(1'b1);
    check("traps", 32'h1, 32'(traps));
    rcheck("osc fail", `OSC_CONTROL_ADDR, 32'h132A);
    check("osc fail", 32'h1008, rd & 32'h7008);
    apb(1'b1, `OSC_CONTROL_ADDR, 32'h030A);
    apb(1'b0, `OSC_CONTROL_ADDR, 32'h0);
    check("fail kept", 32'h8, rd & 32'h0008);
    apb(1'b1, `OSC_CONTROL_ADDR, 32'h000A);
    apb(1'b1, `OSC_CONTROL_ADDR, 32'h000B);
    wait_switch;
    check("osc", 32'h0, rd & 32'h7009);
    @(negedge clk);
    check("enables", 32'h16, 32'(oscEnable));
    apb(1'b1, `OSC_CONTROL_ADDR, 32'h0003);
    apb(1'b0, `OSC_CONTROL_ADDR, 32'h0);
    apb(1'b0, `OSC_CONTROL_ADDR, 32'h0);
    check("redundant", 32'h0, rd & 32'h7001);
  endtask

////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    test_reset_values;
    test_decode;
    test_doze;
    test_disabled;
    reset_n <= 1'b0;
    switchConfigBit <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    test_switch;
    report_and_stop;
  end

  // Hang guard
  initial
  begin
    #2ms;
    badCount++;
    report_and_stop;
  end
endmodule // tb_top
